// >>> hss_pkg.sv
// Shared constants for the high-side switch control block.
// Assumes a 10 MHz system clock; register bus is a plain address/strobe port.
package hss_pkg;

    localparam int NUM_SW = 4;
    localparam int CFG_W = 3;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int SYNC_STAGES = 2;

    // Register offsets
    localparam logic [3:0] ADDR_CTRL_A = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B = 4'h1;
    localparam logic [3:0] ADDR_SUPPLY_CFG = 4'h2;
    localparam logic [3:0] ADDR_SUPPLY_STAT = 4'h3;
    localparam logic [3:0] ADDR_OC_STAT = 4'h4;
    localparam logic [3:0] ADDR_OL_STAT = 4'h5;

    // Supply configuration field positions
    localparam int SCFG_OV_OFF_BIT = 0;
    localparam int SCFG_UV_OFF_BIT = 1;
    localparam int SCFG_RECOVER_BIT = 2;
    localparam int SCFG_W = 3;

    // Supply status field positions
    localparam int SSTAT_OVER_BIT = 0;
    localparam int SSTAT_UNDER_BIT = 1;

    // Switch configuration codes
    localparam logic [2:0] CFG_OFF = 3'h0;
    localparam logic [2:0] CFG_ON = 3'h1;
    localparam logic [2:0] CFG_TIMER1 = 3'h2;
    localparam logic [2:0] CFG_TIMER2 = 3'h3;
    localparam logic [2:0] CFG_PWM1 = 3'h4;
    localparam logic [2:0] CFG_PWM2 = 3'h5;

    // Values after reset
    localparam logic [2:0] SCFG_RST = 3'h0;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // Filter timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int OC_FILTER_NS = 16000;
    localparam int OL_FILTER_NS = 64000;
    localparam int OC_FILTER_CYC = (OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OL_FILTER_CYC = (OL_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        HSS_NORMAL,
        HSS_STOP,
        HSS_SLEEP,
        HSS_RESTART,
        HSS_FAIL_SAFE
    } hss_mode_t;

endpackage

// >>> hss_flt_if.sv
// Condition/trigger pair between the control logic and a filter bank.
// Both sides run on the same system clock.
`timescale 1ns/1ps
interface hss_flt_if #(parameter int N = 4) ();
    logic [N-1:0] cond;
    logic [N-1:0] hit;
    modport src (output cond, input hit);
    modport flt (input cond, output hit);
endinterface

// >>> hss_sync.sv
// Two-flop synchroniser for asynchronous detector levels.
// Inputs come from analog comparators outside the clock domain.
`timescale 1ns/1ps
module hss_sync
#(
    parameter int W = 10
)
(
    // Clock and control
    input logic clk_i,
    input logic srst_i,
    input logic ce_i,
    // Levels
    input logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            meta_reg <= '0;
            sync_o <= '0;
        end
        else if (ce_i)
        begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end

endmodule

// >>> hss_filter.sv
// Bank of persistence filters: hit rises once cond has held CYCLES cycles.
// Condition is on the same clock; hit is combinational from the count.
`timescale 1ns/1ps
module hss_filter
    import hss_pkg::*;
#(
    parameter int N = NUM_SW,
    parameter int CYCLES = OC_FILTER_CYC
)
(
    // Clock and control
    input logic clk_i,
    input logic srst_i,
    input logic ce_i,
    // Conditions in, triggers out
    hss_flt_if.flt flt
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_ch
            logic [CW-1:0] cnt_reg;

            // Any drop-out restarts the window
            always_ff @(posedge clk_i)
            begin
                if (srst_i)
                    cnt_reg <= '0;
                else if (ce_i)
                begin
                    if (!flt.cond[i])
                        cnt_reg <= '0;
                    else if (cnt_reg != LAST)
                        cnt_reg <= cnt_reg + 1'b1;
                end
            end

            assign flt.hit[i] = flt.cond[i] && (cnt_reg == LAST);

            AST_FLT_RESTART: assert property (@(posedge clk_i) disable iff (srst_i)
                (ce_i && !flt.cond[i]) |=> (cnt_reg == '0))
                else $error("filter count not restarted");
            AST_FLT_NEEDS_HOLD: assert property (@(posedge clk_i) disable iff (srst_i)
                flt.hit[i] |-> ($past(flt.cond[i]) || CYCLES == 1))
                else $error("filter hit without held condition");
        end
    endgenerate

endmodule

// >>> hss_switch_ctrl.sv
// Control and protection of four high-side switch outputs.
// Assumes detector levels are asynchronous; timer, PWM and mode inputs
// come from logic on clk_i.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

module hss_switch_ctrl
    import hss_pkg::*;
(
    // Clock, reset, enable
    input logic clk_i,
    input logic srst_i,
    input logic ce_i,
    // Register port
    input logic [ADDR_W-1:0] addr_i,
    input logic [DATA_W-1:0] wdata_i,
    input logic wr_i,
    input logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    // Operating mode and generators
    input hss_mode_t mode_i,
    input logic [1:0] timer_i,
    input logic [1:0] pwm_i,
    // Analog detectors
    input logic supply_over_i,
    input logic supply_under_i,
    input logic [NUM_SW-1:0] oc_i,
    input logic [NUM_SW-1:0] ol_i,
    // Switch drives
    output logic [NUM_SW-1:0] switch_output_o
);

    ////////////////////////////////////////////////////////////////////////////

    logic [NUM_SW-1:0][CFG_W-1:0] cfg_reg;
    logic [SCFG_W-1:0] scfg_reg;
    logic over_flag_reg;
    logic under_flag_reg;
    logic [NUM_SW-1:0] oc_stat_reg;
    logic [NUM_SW-1:0] ol_stat_reg;
    logic [DATA_W-1:0] rdata_next;

    logic [2*NUM_SW+1:0] det_sync;
    logic over_s;
    logic under_s;
    logic [NUM_SW-1:0] oc_s;
    logic [NUM_SW-1:0] ol_s;

    logic ov_cut;
    logic uv_cut;
    logic cut;
    logic recover;
    logic run_mode;
    logic fail_mode;
    logic cfg_we;
    logic [NUM_SW-1:0] req;
    logic [NUM_SW-1:0] hw_clr;
    logic [NUM_SW-1:0] out_next;

    hss_flt_if #(.N(NUM_SW)) oc_if ();
    hss_flt_if #(.N(NUM_SW)) ol_if ();

    // Output request for one configuration code
    function automatic logic cfg_drive(input logic [2:0] code, input logic [1:0] tmr,
                                       input logic [1:0] pwm);
        logic on;
        on = 1'b0;
        case (code)
            CFG_ON: on = 1'b1;
            CFG_TIMER1: on = tmr[0];
            CFG_TIMER2: on = tmr[1];
            CFG_PWM1: on = pwm[0];
            CFG_PWM2: on = pwm[1];
            default: on = 1'b0;
        endcase
        return on;
    endfunction

    // Write-one-to-clear strobe for one status bit
    function automatic logic w1c(input logic we, input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] target, input logic bitv);
        return we && (a == target) && bitv;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Detector inputs

    hss_sync #(.W(2 * NUM_SW + 2)) u_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .async_i({ol_i, oc_i, supply_under_i, supply_over_i}),
        .sync_o(det_sync)
    );

    assign over_s = det_sync[0];
    assign under_s = det_sync[1];
    assign oc_s = det_sync[NUM_SW+1:2];
    assign ol_s = det_sync[2*NUM_SW+1:NUM_SW+2];

    // Both filters look at the driven state, so a switched-off output never trips them
    assign oc_if.cond = oc_s & switch_output_o;
    assign ol_if.cond = ol_s & switch_output_o;

    hss_filter #(.N(NUM_SW), .CYCLES(OC_FILTER_CYC)) u_oc_flt (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .flt(oc_if.flt)
    );

    hss_filter #(.N(NUM_SW), .CYCLES(OL_FILTER_CYC)) u_ol_flt (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .flt(ol_if.flt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Protection decisions

    assign ov_cut = over_s && !scfg_reg[SCFG_OV_OFF_BIT];
    assign uv_cut = under_s && !scfg_reg[SCFG_UV_OFF_BIT];
    assign cut = ov_cut || uv_cut;
    assign recover = scfg_reg[SCFG_RECOVER_BIT];
    assign fail_mode = (mode_i == HSS_RESTART) || (mode_i == HSS_FAIL_SAFE);
    assign run_mode = (mode_i == HSS_NORMAL) || (mode_i == HSS_STOP) || (mode_i == HSS_SLEEP);
    // Stop and sleep refuse configuration writes; only normal mode may write it; hardware clears still apply in every mode
    assign cfg_we = wr_i && (mode_i == HSS_NORMAL);

    genvar g;
    generate
        for (g = 0; g < NUM_SW; g++)
        begin : g_sw
            assign req[g] = cfg_drive(cfg_reg[g], timer_i, pwm_i);
            // Hardware clears beat a software write in the same cycle
            assign hw_clr[g] = oc_if.hit[g]
                || fail_mode
                || (cut && !recover && (cfg_reg[g] != CFG_OFF));
        end
    endgenerate

    // Cut outputs come back by themselves only when auto-recovery keeps the config
    assign out_next = req & ~oc_if.hit & {NUM_SW{!cut && run_mode}};

    ////////////////////////////////////////////////////////////////////////////
    // Switch configuration

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            cfg_reg <= '0;
        else if (ce_i)
        begin
            for (int i = 0; i < NUM_SW; i++)
            begin
                if (hw_clr[i])
                    cfg_reg[i] <= CFG_OFF;
                else if (cfg_we && addr_i == ((i < 2) ? ADDR_CTRL_A : ADDR_CTRL_B))
                    cfg_reg[i] <= wdata_i[(i % 2) * CFG_W +: CFG_W];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            scfg_reg <= SCFG_RST;
        else if (ce_i && cfg_we && addr_i == ADDR_SUPPLY_CFG)
            scfg_reg <= wdata_i[SCFG_W-1:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            switch_output_o <= '0;
        else if (ce_i)
            switch_output_o <= out_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags: a set in the clearing cycle wins

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            over_flag_reg <= 1'b0;
            under_flag_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            over_flag_reg <= over_s
                || (over_flag_reg && !w1c(wr_i, addr_i, ADDR_SUPPLY_STAT, wdata_i[SSTAT_OVER_BIT]));
            under_flag_reg <= under_s
                || (under_flag_reg && !w1c(wr_i, addr_i, ADDR_SUPPLY_STAT, wdata_i[SSTAT_UNDER_BIT]));
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            oc_stat_reg <= '0;
        else if (ce_i)
        begin
            for (int i = 0; i < NUM_SW; i++)
                oc_stat_reg[i] <= oc_if.hit[i]
                    || (oc_stat_reg[i] && !w1c(wr_i, addr_i, ADDR_OC_STAT, wdata_i[i]));
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            ol_stat_reg <= '0;
        else if (ce_i)
        begin
            for (int i = 0; i < NUM_SW; i++)
                ol_stat_reg[i] <= ol_if.hit[i]
                    || (ol_stat_reg[i] && !w1c(wr_i, addr_i, ADDR_OL_STAT, wdata_i[i]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    always_comb
    begin
        rdata_next = '0;
        unique case (addr_i)
            ADDR_CTRL_A: rdata_next = {2'h0, cfg_reg[1], cfg_reg[0]};
            ADDR_CTRL_B: rdata_next = {2'h0, cfg_reg[3], cfg_reg[2]};
            ADDR_SUPPLY_CFG: rdata_next = {5'h00, scfg_reg};
            ADDR_SUPPLY_STAT: rdata_next = {6'h00, under_flag_reg, over_flag_reg};
            ADDR_OC_STAT: rdata_next = {4'h0, oc_stat_reg};
            ADDR_OL_STAT: rdata_next = {4'h0, ol_stat_reg};
            default: rdata_next = '0;
        endcase
    end

    // Data stand for one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            rdata_o <= RDATA_RST;
        else if (ce_i)
            rdata_o <= rd_i ? rdata_next : RDATA_RST;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    AST_OV_CUT: assert property (
        (ce_i && over_s && !scfg_reg[SCFG_OV_OFF_BIT]) |=> (switch_output_o == '0))
        else $error("output on during over-voltage cutoff");
    AST_UV_CUT: assert property (
        (ce_i && under_s && !scfg_reg[SCFG_UV_OFF_BIT]) |=> (switch_output_o == '0))
        else $error("output on during under-voltage cutoff");
    AST_RECOVER: assert property (
        (ce_i && !cut && run_mode && ~|oc_if.hit) |=> (switch_output_o == $past(req)))
        else $error("output does not follow programmed state");
    AST_NO_RECOVER: assert property (
        (ce_i && cut && !recover) |=> (cfg_reg == '0))
        else $error("config kept after fault without auto-recovery");
    AST_SUPPLY_FLAG: assert property (
        (ce_i && over_s) |=> over_flag_reg)
        else $error("over-voltage flag not latched");
    AST_FAIL_OFF: assert property (
        (ce_i && fail_mode) |=> (switch_output_o == '0 && cfg_reg == '0))
        else $error("outputs alive in restart or fail-safe");
    AST_LOCKED: assert property (
        (ce_i && (mode_i == HSS_STOP || mode_i == HSS_SLEEP) && !cut && ~|oc_if.hit) |=> $stable(cfg_reg))
        else $error("config changed in a low-power mode");

    generate
        for (g = 0; g < NUM_SW; g++)
        begin : g_chk
            AST_OC_SHUT: assert property (
                (ce_i && oc_if.hit[g]) |=> (oc_stat_reg[g] && !switch_output_o[g]))
                else $error("over-current did not flag and shut down");
            AST_OC_CFG: assert property (
                (ce_i && oc_if.hit[g]) |=> (cfg_reg[g] == CFG_OFF))
                else $error("config not reset after over-current");
            AST_OL_ON: assert property (
                (ce_i && !ol_stat_reg[g]) ##1 ol_stat_reg[g] |-> $past(switch_output_o[g]))
                else $error("open load flagged while output off");
        end
    endgenerate

    COV_OV_CUT: cover property (ce_i && ov_cut && |req);
    COV_RECOVER: cover property (ce_i && $fell(cut) && recover);
    COV_OC_HIT: cover property (ce_i && |oc_if.hit);
    COV_OL_HIT: cover property (ce_i && |ol_if.hit);

endmodule

// >>> hss_load_model.sv
// Model of the analog switch drivers, load monitors and supply comparators.
// Assumes the bench commands faults; load current flows only while a switch is on.
`timescale 1ns/1ps
module hss_load_model
    import hss_pkg::*;
(
    // Switch drives from the block
    input wire logic [NUM_SW-1:0] sw_i,
    // Faults commanded by the bench
    input wire logic [NUM_SW-1:0] oc_fault_i,
    input wire logic [NUM_SW-1:0] ol_fault_i,
    input wire logic over_i,
    input wire logic under_i,
    // Comparator levels to the block
    output logic [NUM_SW-1:0] oc_o,
    output logic [NUM_SW-1:0] ol_o,
    output logic supply_over_o,
    output logic supply_under_o
);
    // An off switch carries no current, so neither load comparator can trip
    assign oc_o = oc_fault_i & sw_i;
    assign ol_o = ol_fault_i & sw_i;
    assign supply_over_o = over_i;
    assign supply_under_o = under_i;
endmodule

// >>> high_side_switch_protection_tb.sv
// Self-checking bench for the high-side switch control block.
// Assumes the load model above as far side and a 10 MHz clock.
`timescale 1ns/1ps
module high_side_switch_protection_tb;
    import hss_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    hss_mode_t mode_i = HSS_NORMAL;
    logic [1:0] timer_i = '0;
    logic [1:0] pwm_i = '0;
    logic over_f = 1'b0;
    logic under_f = 1'b0;
    logic [NUM_SW-1:0] oc_f = '0;
    logic [NUM_SW-1:0] ol_f = '0;
    logic supply_over_i;
    logic supply_under_i;
    logic [NUM_SW-1:0] oc_i;
    logic [NUM_SW-1:0] ol_i;
    logic [NUM_SW-1:0] switch_output_o;
    logic [7:0] rv;
    int n_errors = 0;
    int total_checks = 0;
    int seed = 47678;
    int rnd;

    always #50 clk_i = ~clk_i;

    hss_switch_ctrl dut_u (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mode_i(mode_i), .timer_i(timer_i), .pwm_i(pwm_i),
        .supply_over_i(supply_over_i), .supply_under_i(supply_under_i), .oc_i(oc_i), .ol_i(ol_i),
        .switch_output_o(switch_output_o));

    hss_load_model load_u (.sw_i(switch_output_o), .oc_fault_i(oc_f), .ol_fault_i(ol_f), .over_i(over_f),
        .under_i(under_f), .oc_o(oc_i), .ol_o(ol_i), .supply_over_o(supply_over_i),
        .supply_under_o(supply_under_i));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just after that edge
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic sw_is(input logic [3:0] e);
        check({4'h0, switch_output_o}, {4'h0, e});
    endtask

    function automatic logic exp_out(input logic [2:0] c, input logic [1:0] t, input logic [1:0] p);
        case (c)
            CFG_ON: return 1'b1;
            CFG_TIMER1: return t[0];
            CFG_TIMER2: return t[1];
            CFG_PWM1: return p[0];
            CFG_PWM2: return p[1];
            default: return 1'b0;
        endcase
    endfunction

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        test_done();
    end

    initial
    begin
        logic e;
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        // Every register, and one unmapped place, reads zero after reset
        for (int a = 0; a < 7; a++)
        begin
            rd(a[3:0], rv);
            check(rv, 8'h00);
        end
        sw_is(4'h0);
        $display("test reset done");
        // All codes, with random generator levels
        for (int c = 0; c < 8; c++)
            for (int r = 0; r < 3; r++)
            begin
                wr(ADDR_CTRL_A, {2'b00, c[2:0], c[2:0]});
                rnd = $random(seed);
                timer_i <= rnd[1:0];
                pwm_i <= rnd[3:2];
                cyc(3);
                e = exp_out(c[2:0], timer_i, pwm_i);
                sw_is({2'b00, e, e});
            end
        timer_i <= 2'h0;
        pwm_i <= 2'h0;
        $display("test sources done");
        // Over-voltage with auto-recovery
        wr(ADDR_SUPPLY_CFG, 8'h04);
        wr(ADDR_CTRL_A, 8'h09);
        cyc(3);
        over_f <= 1'b1;
        cyc(4);
        sw_is(4'h0);
        rd(ADDR_SUPPLY_STAT, rv);
        check(rv, 8'h01);
        rd(ADDR_OC_STAT, rv);
        check(rv, 8'h00);
        rd(ADDR_OL_STAT, rv);
        check(rv, 8'h00);
        over_f <= 1'b0;
        cyc(4);
        sw_is(4'h3);
        rd(ADDR_CTRL_A, rv);
        check(rv, 8'h09);
        rd(ADDR_SUPPLY_STAT, rv);
        check(rv, 8'h01);
        wr(ADDR_SUPPLY_STAT, 8'h01);
        rd(ADDR_SUPPLY_STAT, rv);
        check(rv, 8'h00);
        // Under-voltage without auto-recovery
        wr(ADDR_SUPPLY_CFG, 8'h00);
        under_f <= 1'b1;
        cyc(4);
        sw_is(4'h0);
        rd(ADDR_CTRL_A, rv);
        check(rv, 8'h00);
        under_f <= 1'b0;
        cyc(4);
        sw_is(4'h0);
        rd(ADDR_SUPPLY_STAT, rv);
        check(rv, 8'h02);
        wr(ADDR_SUPPLY_STAT, 8'h02);
        // Both cutoffs disabled: outputs ride through, flags still latch
        wr(ADDR_SUPPLY_CFG, 8'h03);
        wr(ADDR_CTRL_A, 8'h09);
        over_f <= 1'b1;
        under_f <= 1'b1;
        cyc(4);
        sw_is(4'h3);
        rd(ADDR_SUPPLY_STAT, rv);
        check(rv, 8'h03);
        over_f <= 1'b0;
        under_f <= 1'b0;
        // Let the synchronised levels drop first, or the set beats the clear
        cyc(3);
        wr(ADDR_SUPPLY_STAT, 8'h03);
        rd(ADDR_SUPPLY_STAT, rv);
        check(rv, 8'h00);
        wr(ADDR_SUPPLY_CFG, 8'h00);
        $display("test supply done");
        // Over-current: a dropout restarts the filter
        wr(ADDR_CTRL_B, {5'h00, CFG_ON});
        cyc(3);
        oc_f[2] <= 1'b1;
        cyc(100);
        oc_f[2] <= 1'b0;
        cyc(5);
        oc_f[2] <= 1'b1;
        cyc(150);
        sw_is(4'h7);
        cyc(25);
        sw_is(4'h3);
        rd(ADDR_OC_STAT, rv);
        check(rv, 8'h04);
        rd(ADDR_CTRL_B, rv);
        check(rv, 8'h00);
        oc_f[2] <= 1'b0;
        cyc(10);
        rd(ADDR_OC_STAT, rv);
        check(rv, 8'h04);
        wr(ADDR_OC_STAT, 8'h04);
        rd(ADDR_OC_STAT, rv);
        check(rv, 8'h00);
        wr(ADDR_CTRL_B, {5'h00, CFG_ON});
        cyc(3);
        sw_is(4'h7);
        $display("test overcurrent done");
        // Open load on an on output, and on an off one
        ol_f <= 4'hC;
        cyc(600);
        rd(ADDR_OL_STAT, rv);
        check(rv, 8'h00);
        cyc(60);
        rd(ADDR_OL_STAT, rv);
        check(rv, 8'h04);
        sw_is(4'h7);
        ol_f <= 4'h0;
        cyc(5);
        rd(ADDR_OL_STAT, rv);
        check(rv, 8'h04);
        wr(ADDR_OL_STAT, 8'h0F);
        rd(ADDR_OL_STAT, rv);
        check(rv, 8'h00);
        $display("test openload done");
        // Low-power modes lock the configuration but keep driving
        mode_i <= HSS_STOP;
        wr(ADDR_CTRL_A, 8'h00);
        mode_i <= HSS_SLEEP;
        wr(ADDR_SUPPLY_CFG, 8'h07);
        rd(ADDR_CTRL_A, rv);
        check(rv, 8'h09);
        rd(ADDR_SUPPLY_CFG, rv);
        check(rv, 8'h00);
        sw_is(4'h7);
        // Restart and fail-safe both force off until rewritten
        for (int m = 0; m < 2; m++)
        begin
            if (m == 0)
                mode_i <= HSS_RESTART;
            else
                mode_i <= HSS_FAIL_SAFE;
            cyc(3);
            sw_is(4'h0);
            mode_i <= HSS_NORMAL;
            cyc(3);
            sw_is(4'h0);
            wr(ADDR_CTRL_A, 8'h09);
            cyc(3);
            sw_is(4'h3);
        end
        $display("test modes done");
        // A low clock enable freezes everything, register writes included
        ce_i <= 1'b0;
        wr(ADDR_CTRL_A, 8'h00);
        ce_i <= 1'b1;
        cyc(2);
        sw_is(4'h3);
        rd(ADDR_CTRL_A, rv);
        check(rv, 8'h09);
        $display("test enable done");
        test_done();
    end
endmodule
